// >>> core/lpm_wait_ctrl.sv
/*
 * Wait and low-power mode controller: cpu clock gating, peripheral clock
 * gating, on-chip-oscillator low-power detection and pin hold in wait.
 * Assumes software keeps the entry sequence; oscillators arrive as enables.
 */
//------------------------------------------------------------
// Notes on behaviour
// - main stop in oco mode enters lowpower
// - oco lowpower cpu clock is oco divided
// - oco feeds peripherals; sub/32 stays available
// - wait stops cpu and watchdog clock
// - oscillators keep running during wait
// - periph stop bit gates peripheral clocks
// - external bus held during wait
// - ports held during wait
// - strobes high, ale low in wait in external bus mode; dram strobes low in self refresh
// - clock output pin rules in wait
// - reset, nmi or interrupt ends wait
// - wake resumes same cpu clock selection
//------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module lpm_wait_ctrl
	import lpm_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic              i_main_en,
	input  wire logic              i_sub_en,
	input  wire logic              i_oco_en,
	input  wire logic              i_pll_en,
	input  wire logic              i_main_running,
	input  wire logic              i_sub_running,
	input  wire clk_src_t          i_clk_src,
	input  wire logic [DIV_W-1:0]  i_main_divider_ctrl,
	input  wire logic              i_periph_stop_in_wait,
	input  wire clock_output_pin_sel_t       i_clock_output_pin_sel,
	input  wire logic [3:0]        i_pow2_n,
	input  wire logic              i_wait_insn,
	input  wire logic              i_nmi,
	input  wire logic              i_irq_req,
	input  wire logic [2:0]        i_irq_prio,
	input  wire logic              i_irq_enable,
	input  wire logic [2:0]        i_wake_priority_threshold,
	input  wire logic              i_ext_bus_mode,
	input  wire logic              i_self_refresh,
	input  wire ext_bus_t          i_bus,
	input  wire logic [PORT_W-1:0] i_port,
	output logic                   o_cpu_clk_en,
	output logic                   o_wdt_clk_en,
	output periph_clk_t            o_periph,
	output logic                   o_oco_lowpower,
	output logic                   o_in_wait,
	output logic                   o_wake_vector,
	output ext_bus_t               o_bus,
	output logic [PORT_W-1:0]      o_port,
	output logic                   o_clock_output_pin
);
	import lpm_pkg::*;

	//------------------------------------------------------------
	// power state
	//------------------------------------------------------------
	pwr_state_t        state_q;
	logic              wake_ok;
	logic              periph_gate;
	logic              src_en;
	logic              cpu_div_en;
	clk_src_t          src_in_wait_q;

	// wake on nmi always; peripheral interrupt only if enabled and above threshold
	assign wake_ok = i_nmi ||
	                 (i_irq_req && i_irq_enable && (i_irq_prio > i_wake_priority_threshold));

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q <= PWR_RUN;
		end else begin
			unique case (state_q)
				PWR_RUN:  if (i_wait_insn) begin
					state_q <= PWR_WAIT;
				end
				PWR_WAIT: if (wake_ok) begin
					state_q <= PWR_WAKE;
				end
				PWR_WAKE: state_q <= PWR_RUN;
				default:  state_q <= PWR_RUN;
			endcase
		end
	end

	// cpu clock selection captured on wait entry and reused on wake
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			src_in_wait_q <= SRC_MAIN;
		end else if (state_q == PWR_RUN && i_wait_insn) begin
			src_in_wait_q <= i_clk_src;
		end
	end

	assign o_in_wait     = (state_q == PWR_WAIT);
	assign o_wake_vector = (state_q == PWR_WAKE);
	assign periph_gate   = o_in_wait && i_periph_stop_in_wait;

	//------------------------------------------------------------
	// cpu clock
	//------------------------------------------------------------
	clk_src_t eff_src;
	assign eff_src = (state_q == PWR_RUN) ? i_clk_src : src_in_wait_q;

	always_comb begin
		unique case (eff_src)
			SRC_MAIN: src_en = i_main_en;
			SRC_SUB:  src_en = i_sub_en;
			SRC_OCO:  src_en = i_oco_en;
			SRC_PLL:  src_en = i_pll_en;
		endcase
	end

	lpm_cpu_divider u_div (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_src_en ((eff_src == SRC_SUB) ? 1'b0 : src_en),
		.i_div    (i_main_divider_ctrl),
		.o_cpu_en (cpu_div_en)
	);

	logic cpu_en_raw;
	assign cpu_en_raw   = (eff_src == SRC_SUB) ? i_sub_en : cpu_div_en;
	assign o_cpu_clk_en = cpu_en_raw && !o_in_wait;
	assign o_wdt_clk_en = o_cpu_clk_en;

	// main clock stopped while running from the oscillator
	assign o_oco_lowpower = (i_clk_src == SRC_OCO) && !i_main_running;

	//------------------------------------------------------------
	// peripheral clocks
	//------------------------------------------------------------
	logic       per_src_en;
	logic [2:0] cnt8_q;
	logic [4:0] cnt32_q;
	logic [4:0] csub_q;
	logic [15:0] cpow_q;

	// oscillator feeds peripherals whenever it is the cpu source, pll when pll is the source, else main
	assign per_src_en = (i_clk_src == SRC_OCO) ? i_oco_en :
	                    (i_clk_src == SRC_PLL) ? i_pll_en : i_main_en;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt8_q  <= 3'h0;
			cnt32_q <= 5'h00;
			cpow_q  <= 16'h0000;
		end else if (per_src_en && !periph_gate) begin
			cnt8_q  <= cnt8_q + 3'h1;
			cnt32_q <= cnt32_q + 5'h01;
			cpow_q  <= cpow_q + 16'h0001;
		end
	end

	// sub/32 is not affected by the wait-stop bit
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			csub_q <= 5'h00;
		end else if (i_sub_en && i_sub_running) begin
			csub_q <= csub_q + 5'h01;
		end
	end

	logic pow2_hit;
	assign pow2_hit = (i_pow2_n == 4'h0) ? 1'b1 :
	                  ((cpow_q & ((16'h0002 << (i_pow2_n - 4'h1)) - 16'h0001)) ==
	                   ((16'h0002 << (i_pow2_n - 4'h1)) - 16'h0001));

	logic en_ok;
	assign en_ok = per_src_en && !periph_gate;

	always_comb begin
		o_periph.periph_clock_undivided     = en_ok;
		o_periph.periph_clock_div_eight     = en_ok && (cnt8_q == PERIPH_DIV_8);
		o_periph.periph_clock_div_thirtytwo = en_ok && (cnt32_q == PERIPH_DIV_32);
		o_periph.periph_clock_pow2_div      = en_ok && pow2_hit;
		o_periph.converter_clock            = en_ok;
		o_periph.subclock_div_thirtytwo     = i_sub_en && i_sub_running && (csub_q == SUB_DIV_32);
	end

	//------------------------------------------------------------
	// pins
	//------------------------------------------------------------
	ext_bus_t          bus_hold_q;
	logic [PORT_W-1:0] port_hold_q;
	logic              cko_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bus_hold_q  <= '0;
			port_hold_q <= '0;
		end else if (!o_in_wait) begin
			bus_hold_q  <= i_bus;
			port_hold_q <= i_port;
		end
	end

	always_comb begin
		o_bus = bus_hold_q;
		if (o_in_wait && i_ext_bus_mode) begin
			o_bus.rd_n                      = 1'b1;
			o_bus.wr_n                      = 1'b1;
			o_bus.write_low_strobe_n        = 1'b1;
			o_bus.write_high_strobe_n       = 1'b1;
			o_bus.column_strobe_low_byte_n  = !i_self_refresh;
			o_bus.column_strobe_high_byte_n = !i_self_refresh;
			o_bus.row_strobe_n              = !i_self_refresh;
			o_bus.hold_acknowledge_n        = 1'b1;
			o_bus.bclk                      = 1'b1;
			o_bus.ale                       = 1'b0;
		end
	end

	assign o_port = port_hold_q;

	// toggle register for the clock output pin; holds when its source gates off
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cko_q <= 1'b0;
		end else begin
			unique case (i_clock_output_pin_sel)
				CKO_PORT:  cko_q <= 1'b0;
				CKO_SUB:   if (i_sub_en) begin
					cko_q <= !cko_q;
				end
				CKO_DIV8:  if (o_periph.periph_clock_div_eight) begin
					cko_q <= !cko_q;
				end
				CKO_DIV32: if (o_periph.periph_clock_div_thirtytwo) begin
					cko_q <= !cko_q;
				end
			endcase
		end
	end

	assign o_clock_output_pin = cko_q;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	a_cpu_gated_wait: assert property (@(posedge i_clk) disable iff (i_rst)
		o_in_wait |-> !o_cpu_clk_en && !o_wdt_clk_en) else $error("cpu clock ran in wait");
	a_periph_gated: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_in_wait && i_periph_stop_in_wait) |-> o_periph.periph_clock_undivided == 1'b0)
		else $error("peripheral clock ran in wait with stop bit");
	a_lowpower_det: assert property (@(posedge i_clk) disable iff (i_rst)
		o_oco_lowpower == ((i_clk_src == SRC_OCO) && !i_main_running)) else $error("lowpower flag wrong");
	a_wake_step: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_in_wait && wake_ok) |=> o_wake_vector ##1 !o_in_wait) else $error("wake not taken");
	a_wake_qual: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_in_wait && !wake_ok) |=> o_in_wait) else $error("spurious wake");
	a_port_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_in_wait && $past(o_in_wait)) |-> $stable(o_port)) else $error("port moved in wait");
	a_strobe_high: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_in_wait && i_ext_bus_mode && !i_self_refresh) |-> o_bus.rd_n && o_bus.row_strobe_n && !o_bus.ale)
		else $error("strobe level wrong in wait");
	a_addr_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_in_wait && $past(o_in_wait)) |-> $stable(o_bus.addr)) else $error("address moved in wait");
	a_cko_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_in_wait && i_periph_stop_in_wait && i_clock_output_pin_sel == CKO_DIV8 && $past(o_in_wait)) |->
		$stable(o_clock_output_pin)) else $error("clock output toggled while stopped");
	a_src_resume: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == PWR_RUN && i_wait_insn) |=> src_in_wait_q == $past(i_clk_src))
		else $error("wait source not captured");

endmodule : lpm_wait_ctrl
`default_nettype wire

// >>> pkg/lpm_pkg.sv
/*
 * Package for the wait and low-power mode controller: clock source codes,
 * divider codes, pin widths, power modes and the carrier structs.
 * Assumes a single 25 MHz system clock with all clock domains modelled as enables.
 */
package lpm_pkg;

	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int CS_W   = 4;
	localparam int PORT_W = 16;
	localparam int DIV_W  = 5;

	// cpu clock source select
	typedef enum logic [1:0] {
		SRC_MAIN  = 2'h0,
		SRC_SUB   = 2'h1,
		SRC_OCO   = 2'h2,
		SRC_PLL   = 2'h3
	} clk_src_t;

	// clock output pin selection
	typedef enum logic [1:0] {
		CKO_PORT  = 2'h0,
		CKO_SUB   = 2'h1,
		CKO_DIV8  = 2'h2,
		CKO_DIV32 = 2'h3
	} clock_output_pin_sel_t;

	// divider setting codes (divide-by value), peripheral and sub divider terminal counts, top priority
	localparam logic [DIV_W-1:0] DIV_BY_8_CODE   = 5'h08;
	localparam logic [DIV_W-1:0] DIV_RESET_CODE  = 5'h08;
	localparam logic [4:0]       SUB_DIV_32      = 5'h1F;
	localparam logic [2:0]       PERIPH_DIV_8    = 3'h7;
	localparam logic [4:0]       PERIPH_DIV_32   = 5'h1F;
	localparam logic [2:0]       PRIO_MAX        = 3'h7;

	// power state of the core
	typedef enum logic [1:0] {
		PWR_RUN   = 2'b00,
		PWR_WAIT  = 2'b01,
		PWR_WAKE  = 2'b11
	} pwr_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [CS_W-1:0]   cs_n;
		logic              bhe_n;
		logic              rd_n;
		logic              wr_n;
		logic              write_low_strobe_n;
		logic              write_high_strobe_n;
		logic              column_strobe_low_byte_n;
		logic              column_strobe_high_byte_n;
		logic              row_strobe_n;
		logic              hold_acknowledge_n;
		logic              bclk;
		logic              ale;
	} ext_bus_t;

	typedef struct packed {
		logic periph_clock_undivided;
		logic periph_clock_div_eight;
		logic periph_clock_div_thirtytwo;
		logic periph_clock_pow2_div;
		logic converter_clock;
		logic subclock_div_thirtytwo;
	} periph_clk_t;

endpackage : lpm_pkg

// >>> core/lpm_cpu_divider.sv
/*
 * Cpu clock enable divider: turns a source enable into a cpu enable at
 * divide-by 1,2,3,4,6,8,10,12,14,16.
 * Assumes the divide value is one of those; other values fall back to 8.
 */
`timescale 1ns/1ns
`default_nettype none
module lpm_cpu_divider
	import lpm_pkg::*;
(
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_src_en,
	input  wire logic [DIV_W-1:0] i_div,
	output logic                  o_cpu_en
);
	import lpm_pkg::*;

	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] div_eff;

	always_comb begin
		unique case (i_div)
			5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08,
			5'h0A, 5'h0C, 5'h0E, 5'h10: div_eff = i_div;
			default: div_eff = DIV_BY_8_CODE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q <= 5'h00;
		end else if (i_src_en) begin
			if (cnt_q >= div_eff - 5'h01) begin
				cnt_q <= 5'h00;
			end else begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	assign o_cpu_en = i_src_en && (cnt_q >= div_eff - 5'h01);

endmodule : lpm_cpu_divider
`default_nettype wire

// >>> tb/tb_lpm_wait_ctrl.sv
/*
 * Self-checking bench for lpm_wait_ctrl: a cycle model of the wait state and the held
 * pins is compared with the design on every cycle; clock gating is checked by counts over windows.
 * Assumes lpm_pkg and the core files are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_lpm_wait_ctrl;
	import lpm_pkg::*;

	logic              i_clk = 0, i_rst = 1, i_main_en = 0, i_sub_en = 0, i_oco_en = 0, i_pll_en = 0;
	logic              i_main_running = 1, i_sub_running = 1, i_periph_stop_in_wait = 0, i_wait_insn = 0;
	logic              i_nmi = 0, i_irq_req = 0, i_irq_enable = 0, i_ext_bus_mode = 1, i_self_refresh = 0;
	logic [2:0]        i_irq_prio = 3'h0, i_wake_priority_threshold = 3'h7;
	logic [DIV_W-1:0]  i_main_divider_ctrl = 5'h08;
	logic [3:0]        i_pow2_n = 4'h0;
	logic [PORT_W-1:0] i_port = '0, o_port, m_port;
	clk_src_t          i_clk_src = SRC_MAIN;
	clock_output_pin_sel_t       i_clock_output_pin_sel = CKO_PORT;
	ext_bus_t          i_bus = '0, o_bus, m_bus;
	periph_clk_t       o_periph;
	logic              o_cpu_clk_en, o_wdt_clk_en, o_oco_lowpower, o_in_wait, o_wake_vector, o_clock_output_pin;
	logic              last_pin;
	logic [63:0]       r;
	int                n_fail = 0, n_checks = 0, seed = 22, cyc = 0, since = 0, m_wait = 0, m_wake = 0;
	int                n_cpu, n_und, n_s32, n_tog;
	int                divs[$] = '{1, 2, 3, 4, 6, 8, 10, 12, 14, 16};
	int                pr[4] = '{5, 3, 6, 0}, th[4] = '{3, 3, 2, 7}, ie[4] = '{1, 1, 0, 0}, nm[4] = '{0, 0, 0, 1};

	lpm_wait_ctrl u_dut (.i_clk, .i_rst, .i_main_en, .i_sub_en, .i_oco_en, .i_pll_en, .i_main_running,
		.i_sub_running, .i_clk_src, .i_main_divider_ctrl, .i_periph_stop_in_wait, .i_clock_output_pin_sel, .i_pow2_n,
		.i_wait_insn, .i_nmi, .i_irq_req, .i_irq_prio, .i_irq_enable, .i_wake_priority_threshold,
		.i_ext_bus_mode, .i_self_refresh, .i_bus, .i_port, .o_cpu_clk_en, .o_wdt_clk_en, .o_periph,
		.o_oco_lowpower, .o_in_wait, .o_wake_vector, .o_bus, .o_port, .o_clock_output_pin);

	always #20 i_clk = ~i_clk;

	//------------------------------------------------------------
	// compare and report
	//------------------------------------------------------------
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	task chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, msg, got, exp);
		end
	endtask : chk

	task chk_rng(input int got, input int lo, input int hi, input string msg);
		n_checks++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("unexpected at %0t: %s count %0d not in %0d..%0d", $time, msg, got, lo, hi);
		end
	endtask : chk_rng

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			$display("unexpected at %0t: run did not finish", $time);
			end_of_test;
		end
	end

	//------------------------------------------------------------
	// one cycle: compare at the falling edge, step the model at the rising edge
	//------------------------------------------------------------
	task tick;
		int o;
		int wk;
		@(negedge i_clk);
		chk(o_in_wait, m_wait[0], "in wait");
		chk(o_wake_vector, m_wake[0], "wake pulse");
		if (since > 0) chk(o_port, m_port, "port");
		if (m_wait != 0) begin
			chk({o_cpu_clk_en, o_wdt_clk_en}, 0, "cpu clock");
			chk({o_bus.addr, o_bus.data, o_bus.cs_n, o_bus.bhe_n},
				{m_bus.addr, m_bus.data, m_bus.cs_n, m_bus.bhe_n}, "bus hold");
			chk({o_bus.rd_n, o_bus.wr_n, o_bus.write_low_strobe_n, o_bus.write_high_strobe_n,
				o_bus.hold_acknowledge_n, o_bus.bclk, o_bus.ale}, 7'h7E, "strobes");
			chk({o_bus.column_strobe_low_byte_n, o_bus.column_strobe_high_byte_n, o_bus.row_strobe_n},
				{3{~i_self_refresh}}, "dram strobes");
		end else if (since > 0) chk(o_bus, m_bus, "bus copy");
		n_cpu += o_cpu_clk_en;
		n_und += o_periph.periph_clock_undivided;
		n_s32 += o_periph.subclock_div_thirtytwo;
		n_tog += (o_clock_output_pin !== last_pin);
		last_pin = o_clock_output_pin;
		@(posedge i_clk);
		wk = i_nmi | (i_irq_req & i_irq_enable & (i_irq_prio > i_wake_priority_threshold));
		o = m_wait;
		if (i_rst) begin
			m_wait = 0;
			m_wake = 0;
			since = 0;
		end else begin
			if (o == 0) begin
				m_port = i_port;
				m_bus = i_bus;
			end
			m_wait = o ? !wk : (i_wait_insn && m_wake == 0);
			m_wake = o && wk;
			since++;
		end
		#1;
		r = {$random(seed), $random(seed)};
		i_port = r[63:48];
		i_bus = r[$bits(ext_bus_t)-1:0];
	endtask : tick

	task run(input int n);
		repeat (n) tick;
	endtask : run

	task zero;
		n_cpu = 0;
		n_und = 0;
		n_s32 = 0;
		n_tog = 0;
	endtask : zero

	task enter;
		i_irq_enable = 0;
		i_wait_insn = 1;
		tick;
		i_wait_insn = 0;
		tick;
	endtask : enter

	task wake_nmi;
		i_nmi = 1;
		tick;
		i_nmi = 0;
		i_wake_priority_threshold = 3'h7;
		run(2);
	endtask : wake_nmi

	//------------------------------------------------------------
	// tests
	//------------------------------------------------------------
	initial begin
		run(4);
		i_rst = 0;
		run(2);
		for (int k = 0; k < 4; k++) begin
			i_self_refresh = k[0];
			enter;
			{i_irq_req, i_irq_prio, i_wake_priority_threshold} = {1'b1, pr[k][2:0], th[k][2:0]};
			{i_irq_enable, i_nmi} = {ie[k][0], nm[k][0]};
			run(3);
			{i_irq_req, i_nmi} = 2'h0;
			if (m_wait != 0) wake_nmi;
		end
		$display("test wake decisions done");
		enter;
		i_rst = 1;
		tick;
		i_rst = 0;
		run(2);
		$display("test reset in wait done");
		{i_main_en, i_sub_en, i_clock_output_pin_sel} = {2'h3, CKO_DIV8};
		for (int s = 0; s < 2; s++) begin
			i_periph_stop_in_wait = s[0];
			enter;
			zero;
			run(64);
			chk_rng(n_und, s ? 0 : 60, s ? 0 : 64, "undivided");
			chk_rng(n_s32, 1, 3, "sub div32");
			chk_rng(n_tog, s ? 0 : 6, s ? 0 : 10, "clock out div8");
			wake_nmi;
		end
		i_clock_output_pin_sel = CKO_SUB;
		enter;
		zero;
		run(16);
		chk_rng(n_tog, 8, 16, "clock out sub");
		wake_nmi;
		$display("test wait clocks done");
		{i_clk_src, i_main_running, i_oco_en, i_main_en} = {SRC_OCO, 3'h2};
		run(2);
		chk(o_oco_lowpower, 1, "low power");
		foreach (divs[j]) begin
			i_main_divider_ctrl = divs[j][4:0];
			run(20);
			zero;
			run(240);
			chk_rng(n_cpu, 240 / divs[j] - 1, 240 / divs[j] + 1, "cpu divide");
			chk_rng(n_und, 240, 240, "oco periph");
		end
		i_main_divider_ctrl = 5'h08;
		i_main_running = 1;
		tick;
		chk(o_oco_lowpower, 0, "low power off");
		$display("test oco low power done");
		end_of_test;
	end
endmodule : tb_lpm_wait_ctrl
`default_nettype wire
